// [design/dac_channel_one_control.v]
// Functional notes
// - Control bit 1 set turns the output buffer off; clear keeps it on.
// - Control bit 2 enables trigger-driven loading of the output data.
// - Bits 5:3 choose the trigger source, used only while triggers are enabled.
// - Codes 0-5 pick timer triggers, 6 external line nine, 7 software trigger.
// - Bits 7:6 choose none, noise, or triangle (upper bit set) waveform.
// - Bits 11:8 give noise unmask width or triangle peak amplitude.
// - Code k unmasks bits k..0 and sets triangle peak 2^(k+1)-1.
// - Codes eleven and above unmask all twelve bits, full-scale amplitude.
// - Control bit 12 enables DMA requests for the first channel.
// - Control bit 13 enables the DMA underrun interrupt.
// - Without triggers, a holding write reaches output data one cycle later.
// - Timer or external trigger copies after three cycles, software after one.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`include "dac_one_defines.vh"

module dac_channel_one_control
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire [5:0] timer_trigger_output,
  input wire exti_line9,
  input wire dma_ack,
  output reg chan_one_on,
  output reg chan_one_buffer_off,
  output reg [11:0] dac_value,
  output reg dma_request,
  output reg irq
);

  // ************************************************************
  // Register state.
  // ************************************************************
  reg [`CTL_WIDTH-1:0] control_r;
  reg [`DATA_W-1:0] holding_r;
  reg [`DATA_W-1:0] output_r;
  reg [`ST_WIDTH-1:0] status_r;
  reg [`ST_WIDTH-1:0] mask_r;
  reg [`DATA_W-1:0] lfsr_r;
  reg [`DATA_W-1:0] tri_r;
  reg tri_down_r;
  reg load_pending_r;
  reg soft_trig_r;

  // Bus data phase bookkeeping.
  reg dp_write_r;
  reg [7:0] dp_addr_r;

  // Trigger input synchronisers; stage one is read only by stage two.
  reg [6:0] trig_s1_r;
  reg [6:0] trig_s2_r;
  reg [6:0] trig_s3_r;

  // ************************************************************
  // Control field views.
  // ************************************************************
  wire trig_on = control_r[`CTL_TRIG_ON];
  wire [2:0] trig_src = control_r[`CTL_SRC_HI:`CTL_SRC_LO];
  wire [1:0] wave_sel = control_r[`CTL_WAVE_HI:`CTL_WAVE_LO];
  wire [3:0] mamp_sel = control_r[`CTL_MAMP_HI:`CTL_MAMP_LO];
  wire dma_on = control_r[`CTL_DMA_ON];
  wire udr_irq_on = control_r[`CTL_UDR_IRQ];
  wire chan_on = control_r[`CTL_ON];

  // ************************************************************
  // Bus decode.
  // ************************************************************
  // The slave never stalls, so the address phase is taken whenever hready is high.
  wire addr_take = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;
  wire wr_now = dp_write_r;
  wire wr_ctl = wr_now & (dp_addr_r == `OFF_CONTROL);
  wire wr_sw = wr_now & (dp_addr_r == `OFF_SWTRIG);
  wire wr_hold = wr_now & (dp_addr_r == `OFF_HOLDING);
  wire wr_stat = wr_now & (dp_addr_r == `OFF_STATUS);
  wire wr_mask = wr_now & (dp_addr_r == `OFF_MASK);

  // ************************************************************
  // Trigger selection.
  // ************************************************************
  // Rising edges of the synchronised hardware trigger pins.
  wire [6:0] trig_edge = trig_s2_r & ~trig_s3_r;
  reg trig_fire;

  // Only the chosen source counts, and only while triggers are enabled.
  always @*
  begin
    trig_fire = 1'b0;
    if (trig_on & (trig_src == `SRC_SOFT))
    begin
      trig_fire = soft_trig_r;
    end
    else if (trig_on & (trig_src == `SRC_EXTI))
    begin
      trig_fire = trig_edge[`TIMER_COUNT];
    end
    else if (trig_on)
    begin
      trig_fire = trig_edge[trig_src];
    end
  end

  // ************************************************************
  // Waveform amplitude mask.
  // ************************************************************
  // Codes at or above eleven saturate to all twelve bits.
  wire [3:0] mamp_eff = (mamp_sel >= `MAMP_TOP) ? `MAMP_TOP : mamp_sel;
  wire [3:0] mamp_shift = `MAMP_TOP - mamp_eff;
  wire [`DATA_W-1:0] amp_mask = `MASK_FULL >> mamp_shift;

  // ************************************************************
  // Load decision and next output value.
  // ************************************************************
  // A copy happens either one cycle after a holding write with triggers off,
  // or on the selected trigger; a disabled channel ignores both.
  wire copy_now = chan_on & (trig_on ? trig_fire : load_pending_r);
  wire noise_mode = (wave_sel == `WAVE_NOISE);
  wire tri_mode = wave_sel[1];
  wire wave_step = copy_now & (wave_sel != `WAVE_NONE);
  wire [`DATA_W-1:0] lfsr_fb = {lfsr_r[`DATA_W-2:0], lfsr_r[11] ^ lfsr_r[5] ^ lfsr_r[3] ^ lfsr_r[0]};
  reg [`DATA_W-1:0] wave_add;
  reg [`DATA_W-1:0] output_nxt;

  // Noise adds the unmasked shift-register bits; triangle adds the counter.
  always @*
  begin
    wave_add = `DATA_RESET;
    if (noise_mode)
    begin
      wave_add = lfsr_r & amp_mask;
    end
    else if (tri_mode)
    begin
      wave_add = tri_r;
    end
    output_nxt = holding_r + wave_add;
  end

  // ************************************************************
  // Triangle counter next state.
  // ************************************************************
  reg [`DATA_W-1:0] tri_nxt;
  reg tri_down_nxt;

  // The counter climbs to the selected peak, then falls back to zero.
  always @*
  begin
    tri_nxt = tri_r;
    tri_down_nxt = tri_down_r;
    if (wave_step & tri_mode & ~tri_down_r & (tri_r >= amp_mask))
    begin
      tri_down_nxt = 1'b1;
      tri_nxt = amp_mask - `ONE12;
    end
    else if (wave_step & tri_mode & ~tri_down_r)
    begin
      tri_nxt = tri_r + `ONE12;
    end
    else if (wave_step & tri_mode & (tri_r == `DATA_RESET))
    begin
      tri_down_nxt = 1'b0;
      tri_nxt = `ONE12;
    end
    else if (wave_step & tri_mode)
    begin
      tri_nxt = tri_r - `ONE12;
    end
  end

  // ************************************************************
  // Status events.
  // ************************************************************
  // An underrun is a new trigger while the previous DMA request is unserved.
  wire ev_underrun = copy_now & trig_on & dma_on & dma_request & ~dma_ack;
  wire [`ST_WIDTH-1:0] ev_vec = {copy_now, ev_underrun};
  // Set wins over a write-one clear in the same cycle, so no event is lost.
  wire [`ST_WIDTH-1:0] clr_vec = wr_stat ? hwdata[`ST_WIDTH-1:0] : `ST_RESET;
  wire [`ST_WIDTH-1:0] status_nxt = (status_r & ~clr_vec) | ev_vec;
  // The underrun bit only reaches the line when its enable is set.
  wire [`ST_WIDTH-1:0] irq_gate = {1'b1, udr_irq_on};
  wire irq_nxt = |(status_nxt & mask_r & irq_gate);

  // ************************************************************
  // Read data for the address phase.
  // ************************************************************
  reg [31:0] rdata_nxt;

  // Data is fetched at the address phase so hrdata comes from a flop.
  always @*
  begin
    rdata_nxt = `WORD_ZERO;
    if (haddr[7:0] == `OFF_CONTROL)
    begin
      rdata_nxt[`CTL_WIDTH-1:0] = control_r;
    end
    else if (haddr[7:0] == `OFF_HOLDING)
    begin
      rdata_nxt[`DATA_W-1:0] = holding_r;
    end
    else if (haddr[7:0] == `OFF_OUTPUT)
    begin
      rdata_nxt[`DATA_W-1:0] = output_r;
    end
    else if (haddr[7:0] == `OFF_STATUS)
    begin
      rdata_nxt[`ST_WIDTH-1:0] = status_r;
    end
    else if (haddr[7:0] == `OFF_MASK)
    begin
      rdata_nxt[`ST_WIDTH-1:0] = mask_r;
    end
  end

  // ************************************************************
  // Bus slave flops.
  // ************************************************************
  // Upper address bits are not decoded; the block sees a 256-byte window.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= `WORD_ZERO;
      dp_write_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_write_r <= addr_take & hwrite;
      if (addr_take)
      begin
        dp_addr_r <= haddr[7:0];
      end
      if (addr_take & ~hwrite)
      begin
        hrdata <= rdata_nxt;
      end
    end
  end

  // ************************************************************
  // Trigger synchronisers.
  // ************************************************************
  // Two stages for metastability, a third only for edge detection.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trig_s1_r <= 7'h00;
      trig_s2_r <= 7'h00;
      trig_s3_r <= 7'h00;
    end
    else
    begin
      trig_s1_r <= {exti_line9, timer_trigger_output};
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
    end
  end

  // ************************************************************
  // Software-visible registers.
  // ************************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      control_r <= `CTL_RESET;
      holding_r <= `DATA_RESET;
      mask_r <= `ST_RESET;
      status_r <= `ST_RESET;
      load_pending_r <= 1'b0;
      soft_trig_r <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
      begin
        control_r <= hwdata[`CTL_WIDTH-1:0];
      end
      if (wr_hold)
      begin
        holding_r <= hwdata[`DATA_W-1:0];
      end
      if (wr_mask)
      begin
        mask_r <= hwdata[`ST_WIDTH-1:0];
      end
      status_r <= status_nxt;
      // The pending copy fires on the next edge, one cycle after the write.
      load_pending_r <= wr_hold & ~trig_on;
      // Writing bit 0 of the trigger register gives a single-cycle pulse.
      soft_trig_r <= wr_sw & hwdata[0];
    end
  end

  // ************************************************************
  // Output data path and waveform generators.
  // ************************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      output_r <= `DATA_RESET;
      lfsr_r <= `LFSR_SEED;
      tri_r <= `DATA_RESET;
      tri_down_r <= 1'b0;
    end
    else
    begin
      if (copy_now)
      begin
        output_r <= output_nxt;
      end
      if (wave_step & noise_mode)
      begin
        lfsr_r <= lfsr_fb;
      end
      tri_r <= tri_nxt;
      tri_down_r <= tri_down_nxt;
    end
  end

  // ************************************************************
  // Pin-facing outputs.
  // ************************************************************
  // Each trigger with DMA on asks for the next sample; the ack retires it.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      chan_one_on <= 1'b0;
      chan_one_buffer_off <= 1'b0;
      dac_value <= `DATA_RESET;
      dma_request <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      chan_one_on <= chan_on;
      chan_one_buffer_off <= control_r[`CTL_BUF_OFF];
      dac_value <= output_r;
      if (copy_now & trig_on & dma_on)
      begin
        dma_request <= 1'b1;
      end
      else if (dma_ack | ~dma_on)
      begin
        dma_request <= 1'b0;
      end
      irq <= irq_nxt;
    end
  end

endmodule

// [design/dac_one_defines.vh]
`ifndef DAC_ONE_DEFINES_VH
`define DAC_ONE_DEFINES_VH

// ************************************************************
// Register byte offsets.
// ************************************************************
`define OFF_CONTROL 8'h00
`define OFF_SWTRIG 8'h04
`define OFF_HOLDING 8'h08
`define OFF_OUTPUT 8'h2c
`define OFF_STATUS 8'h34
`define OFF_MASK 8'h38

// ************************************************************
// Control register fields.
// ************************************************************
`define CTL_ON 0
`define CTL_BUF_OFF 1
`define CTL_TRIG_ON 2
`define CTL_SRC_HI 5
`define CTL_SRC_LO 3
`define CTL_WAVE_HI 7
`define CTL_WAVE_LO 6
`define CTL_MAMP_HI 11
`define CTL_MAMP_LO 8
`define CTL_DMA_ON 12
`define CTL_UDR_IRQ 13
`define CTL_WIDTH 14
`define CTL_RESET 14'h0000

// ************************************************************
// Trigger sources, wave codes and status bits.
// ************************************************************
`define SRC_EXTI 3'h6
`define SRC_SOFT 3'h7
`define TIMER_COUNT 6
`define WAVE_NONE 2'h0
`define WAVE_NOISE 2'h1
`define ST_UNDERRUN 0
`define ST_LOADED 1
`define ST_WIDTH 2
`define ST_RESET 2'h0

// ************************************************************
// Data path constants.
// ************************************************************
`define DATA_W 12
`define DATA_RESET 12'h000
`define LFSR_SEED 12'haaa
`define MAMP_TOP 4'hb
`define MASK_FULL 12'hfff
`define ONE12 12'h001
`define WORD_ZERO 32'h00000000
`define HTRANS_NONSEQ_BIT 1

`endif

// [dv/dac_one_properties.sv]
`timescale 1ns/1ps
module dac_one_checker
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire dma_ack,
  input wire chan_one_on,
  input wire chan_one_buffer_off,
  input wire [11:0] dac_value,
  input wire dma_request,
  input wire irq
);
  reg wr_q;
  reg rd0_q;
  reg [7:0] ad_q;
  reg [13:0] ctl_q;
  reg [1:0] msk_q;

  // Shadow of the control and mask words, so outputs can be tied to what software wrote.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      rd0_q <= 1'b0;
      ad_q <= 8'h00;
      ctl_q <= 14'h0000;
      msk_q <= 2'h0;
    end
    else
    begin
      wr_q <= hsel & htrans[1] & hready & hwrite;
      rd0_q <= hsel & htrans[1] & hready & ~hwrite & (haddr[7:0] == 8'h00);
      ad_q <= haddr[7:0];
      if (wr_q && ad_q == 8'h00)
        ctl_q <= hwdata[13:0];
      if (wr_q && ad_q == 8'h38)
        msk_q <= hwdata[1:0];
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ready_high_a: assert property (hreadyout == 1'b1) else $error("hreadyout low");
  resp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
  chan_on_a: assert property (wr_q && ad_q == 8'h00 |-> ##[1:2] chan_one_on == ctl_q[0])
    else $error("channel enable wrong");
  buffer_off_a: assert property (wr_q && ad_q == 8'h00 |-> ##[1:2] chan_one_buffer_off == ctl_q[1])
    else $error("buffer disable wrong");
  ctl_read_a: assert property (rd0_q |-> hrdata == {18'h0, ctl_q})
    else $error("control readback wrong");
  dma_enable_a: assert property ($rose(dma_request) |-> ctl_q[12] && ctl_q[2])
    else $error("dma request while disabled");
  dma_ack_a: assert property (dma_request && dma_ack |=> !dma_request)
    else $error("dma request not cleared");
  irq_gate_a: assert property ($rose(irq) |-> msk_q[1] || (msk_q[0] && ctl_q[13]))
    else $error("irq without enable");
  dac_hold_a: assert property ($changed(dac_value) |-> ctl_q[0])
    else $error("output changed while channel off");
endmodule

bind dac_channel_one_control dac_one_checker dac_one_checker_inst
(
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
  .hrdata, .dma_ack, .chan_one_on, .chan_one_buffer_off, .dac_value, .dma_request, .irq
);

// [dv/tb_dac_channel_one_control.sv]
`timescale 1ns/1ps
module tb_dac_channel_one_control;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [5:0] timer_trigger_output = 6'h0;
  logic exti_line9 = 1'b0;
  logic dma_ack = 1'b0;
  wire hreadyout, hresp, chan_one_on, chan_one_buffer_off, dma_request, irq;
  wire [31:0] hrdata;
  wire [11:0] dac_value;
  int n_errors = 0;
  int n_tests = 0;
  int mx;
  logic [31:0] d;
  logic [31:0] ex;
  logic [31:0] wctl [4] = '{32'h181, 32'h2c1, 32'h41, 32'hf41};
  int wpk [4] = '{3, 7, 1, 4095};

  // 40 MHz bus clock.
  always #12.5 hclk = ~hclk;

  dac_channel_one_control dac_channel_one_control_inst
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .timer_trigger_output, .exti_line9, .dma_ack,
    .chan_one_on, .chan_one_buffer_off, .dac_value, .dma_request, .irq
  );

  // ************************************************************
  // Bus and check tasks.
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single transfer; the wait loops never assume the zero-wait answer.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    if (w)
      hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  // Wait n edges, then step past them so outputs have settled.
  task automatic look(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // A three-cycle pulse on trigger pin i, where 6 is the external line.
  task automatic pulse(input int i);
    @(posedge hclk);
    if (i == 6)
      exti_line9 <= 1'b1;
    else
      timer_trigger_output[i] <= 1'b1;
    repeat (3) @(posedge hclk);
    exti_line9 <= 1'b0;
    timer_trigger_output <= 6'h0;
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ************************************************************
  // Test sequence.
  // ************************************************************
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h00);
    chk("control_reset", 32'h0, d);
    rd(8'h40);
    chk("unmapped", 32'h0, d);
    wr(8'h08, 32'h5a5);
    look(3);
    chk("copy_while_off", 32'h0, dac_value);
    wr(8'h00, 32'h3);
    look(2);
    chk("chan_on", 32'h1, chan_one_on);
    chk("buffer_off", 32'h1, chan_one_buffer_off);
    wr(8'h00, 32'h1);
    look(2);
    chk("buffer_on", 32'h0, chan_one_buffer_off);
    wr(8'h08, 32'h123);
    look(1);
    chk("early_copy", 32'h0, dac_value);
    look(1);
    chk("direct_copy", 32'h123, dac_value);
    wr(8'h00, 32'h3d);
    wr(8'h08, 32'h2bc);
    look(3);
    chk("no_self_copy", 32'h123, dac_value);
    wr(8'h04, 32'h1);
    look(1);
    chk("soft_early", 32'h123, dac_value);
    look(1);
    chk("soft_copy", 32'h2bc, dac_value);
    ex = 32'h2bc;
    // Every hardware source code (0 to 6), each first offered a pulse on a pin it must ignore.
    for (int c = 0; c < 7; c++)
    begin
      wr(8'h00, 32'h5 | (c << 3));
      wr(8'h08, 32'h300 + c);
      pulse((c + 1) % 7);
      look(6);
      chk("wrong_source", ex, dac_value);
      pulse(c);
      #1;
      chk("trig_early", ex, dac_value);
      ex = 32'h300 + c;
      look(1);
      chk("trig_copy", ex, dac_value);
    end
    wr(8'h38, 32'h1);
    wr(8'h00, 32'h3d);
    wr(8'h04, 32'h1);
    look(3);
    chk("dma_off", 32'h0, dma_request);
    wr(8'h00, 32'h303d);
    rd(8'h00);
    chk("control_rw", 32'h303d, d);
    wr(8'h04, 32'h1);
    look(3);
    chk("dma_req", 32'h1, dma_request);
    wr(8'h04, 32'h1);
    look(3);
    chk("underrun_irq", 32'h1, irq);
    rd(8'h34);
    chk("status", 32'h3, d);
    @(posedge hclk);
    dma_ack <= 1'b1;
    @(posedge hclk);
    dma_ack <= 1'b0;
    #1;
    chk("dma_ack", 32'h0, dma_request);
    wr(8'h00, 32'h103d);
    look(2);
    chk("irq_gated", 32'h0, irq);
    wr(8'h00, 32'h303d);
    look(2);
    chk("irq_ungated", 32'h1, irq);
    wr(8'h34, 32'h1);
    look(2);
    chk("irq_cleared", 32'h0, irq);
    // Waves over a zero holding value: the output is the wave term alone.
    foreach (wctl[k])
    begin
      wr(8'h00, wctl[k]);
      mx = 0;
      repeat (8)
      begin
        wr(8'h08, 32'h0);
        look(2);
        if (dac_value > mx)
          mx = dac_value;
      end
      chk("wave_bound", 32'h1, 32'(mx <= wpk[k]));
      if (wctl[k][7])
        chk("tri_peak", wpk[k], mx);
      // A saturated selector must let the top shift-register bit through.
      if (wctl[k][11:8] > 4'ha)
        chk("noise_full", 32'h1, 32'(mx > 2047));
    end
    give_verdict();
  end

  // Whole run takes a few hundred cycles; 20000 means a hang.
  initial
  begin
    #500000;
    n_errors++;
    give_verdict();
  end
endmodule
